// file: pkg/fmsbp_pkg.sv
/*
  fmsbp_pkg: constants shared by the field memory serial block port design.
  assumes: nothing outside; every file names members as fmsbp_pkg::name.
*/
package fmsbp_pkg;
  localparam int ADDR_W = 18;
  localparam int ROW_W = 9;
  localparam int ROW_LSB = 0;
  localparam int COL_LSB = 9;
  localparam int ROWS = 270;
  localparam int COLS = 288;
  localparam int WORD_W = 8;
  localparam int WORDS = 8;
  localparam int BLOCK_W = 64;
  localparam int PTR_W = 3;
  localparam int FIFO_DEPTH = 32;
  localparam logic [2:0] PTR_RST = 3'h0;
  localparam logic [8:0] ROW_RST = 9'h000;
  localparam logic [8:0] ROW_LAST = 9'h10D;
  localparam logic [7:0] WORD_ZERO = 8'h00;
  localparam logic [63:0] BLOCK_RST = 64'h0000000000000000;
endpackage

// file: core/fmsbp_fifo.sv
/*
  fmsbp_fifo: small synchronous fifo with valid/ready on both sides.
  assumes: single clock core_clk, asynchronous active-low reset.
*/
`timescale 1ns/10ps
module fmsbp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = !full;
  assign push = in_valid && !full;
  assign pop = !empty && (!out_valid || out_ready);

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  // read data leaves from a register
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_data <= '0;
      out_valid <= 1'b0;
    end else if (pop) begin
      out_data <= mem[rd_ptr[AW-1:0]];
      out_valid <= 1'b1;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule

// file: core/fmsbp_array.sv
/*
  fmsbp_array: block memory, one 64-bit word per folded row/column index.
  assumes: single clock; read data registered; depth kept small by parameter.
*/
`timescale 1ns/10ps
module fmsbp_array #(
  parameter int AW = 10,
  parameter int DW = 64
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] addr,
  input wire logic wr_en,
  input wire logic [DW-1:0] wr_data,
  input wire logic rd_en,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wr_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[addr];
    end
  end
endmodule

// file: core/fmsbp_top.sv
/*
  fmsbp_top: field memory with serial shift-in/shift-out block ports.
  assumes: all strobes, serial clocks and pins are asynchronous to core_clk
  and are sampled through two flops; serial clocks run slower than core_clk/4.
*/
// Contract
// - latch address at strobe fall, row/column split
// - block select sampled with address gates access
// - output enable, force zero, normal drive
// - write strobe fall copies shift-in to latch
// - cycle strobe and array write strobe write latch
// - read strobe moves block into shift-out
// - serial-in rise captures next word
// - serial-out rise presents next word, held
// - first word on first clock after read strobe
// - shift-out wraps as eight word loop
// - words after write strobe go next transfer
// - ninth serial-in overwrites, first word lost
// - direction select swaps port roles
// - read-modify-write within one array cycle
// - strobe-only refresh uses low address bits
// - auto refresh pulse uses internal row counter
// - data pins high impedance after power up
`timescale 1ns/10ps
module fmsbp_top #(
  parameter int ARRAY_AW = 10,
  parameter int FIFO_DEPTH = fmsbp_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [17:0] addr,
  input wire logic cycle_strobe_n,
  input wire logic block_sel,
  input wire logic out_enable_n,
  input wire logic write_strobe_n,
  input wire logic array_write_n,
  input wire logic read_strobe_n,
  input wire logic serial_in_clk,
  input wire logic serial_out_clk,
  input wire logic port_direction_sel,
  input wire logic force_zero_out,
  input wire logic auto_refresh_n,
  input wire logic internal_reset_n,
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n,
  output logic [8:0] refresh_row,
  output logic refresh_pulse,
  output logic fifo_full
);
  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; stage one feeds stage two only
  localparam int NS = 13;
  logic [NS-1:0] meta;
  logic [NS-1:0] sync;
  logic [NS-1:0] sync_d;
  logic [17:0] addr_m;
  logic [17:0] addr_s;
  logic [7:0] pa_m;
  logic [7:0] pa_s;
  logic [7:0] pb_m;
  logic [7:0] pb_s;
  logic [NS-1:0] raw;

  assign raw = {internal_reset_n, block_sel, out_enable_n, write_strobe_n, array_write_n,
    read_strobe_n, serial_in_clk, serial_out_clk, port_direction_sel, force_zero_out,
    auto_refresh_n, cycle_strobe_n, 1'b0};

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= 13'h1FFE;
      sync <= 13'h1FFE;
      sync_d <= 13'h1FFE;
      addr_m <= 18'h00000;
      addr_s <= 18'h00000;
      pa_m <= 8'h00;
      pa_s <= 8'h00;
      pb_m <= 8'h00;
      pb_s <= 8'h00;
    end else begin
      meta <= raw;
      sync <= meta;
      sync_d <= sync;
      addr_m <= addr;
      addr_s <= addr_m;
      pa_m <= port_a_in;
      pa_s <= pa_m;
      pb_m <= port_b_in;
      pb_s <= pb_m;
    end
  end

  logic s_rst_n, s_bsel, s_oe_n, s_dir, s_fz;
  logic ce_fall, ce_low, ws_fall, we_low, rs_fall, rs_low, sic_rise, soc_rise, rf_fall;
  assign s_rst_n = sync[12];
  assign s_bsel = sync[11];
  assign s_oe_n = sync[10];
  assign s_dir = sync[4];
  assign s_fz = sync[3];
  assign ce_low = !sync[1];
  assign ce_fall = !sync[1] && sync_d[1];
  assign ws_fall = !sync[9] && sync_d[9];
  assign we_low = !sync[8];
  assign rs_low = !sync[7];
  assign rs_fall = !sync[7] && sync_d[7];
  assign sic_rise = sync[6] && !sync_d[6];
  assign soc_rise = sync[5] && !sync_d[5];
  assign rf_fall = !sync[2] && sync_d[2];

  function automatic logic [ARRAY_AW-1:0] blk_index(input logic [17:0] a);
    // folded to the modelled array depth; a full part would use row*288+col
    blk_index = ARRAY_AW'(a[fmsbp_pkg::ROW_W-1:0] ^ {a[17:9], 1'b0});
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // array cycle: address latch and block selection
  logic [17:0] lat_addr;
  logic lat_sel;
  logic wr_done;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lat_addr <= 18'h00000;
      lat_sel <= 1'b0;
    end else if (ce_fall) begin
      lat_addr <= addr_s;
      lat_sel <= s_bsel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refresh: strobe-only uses latched row, auto uses internal counter
  logic [8:0] rf_count;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rf_count <= fmsbp_pkg::ROW_RST;
      refresh_row <= fmsbp_pkg::ROW_RST;
      refresh_pulse <= 1'b0;
    end else if (!s_rst_n) begin
      rf_count <= fmsbp_pkg::ROW_RST;
      refresh_pulse <= 1'b0;
    end else begin
      refresh_pulse <= 1'b0;
      if (ce_fall && !s_bsel) begin
        refresh_row <= addr_s[fmsbp_pkg::ROW_W-1:0];
        refresh_pulse <= 1'b1;
      end else if (rf_fall && !ce_low) begin
        refresh_row <= rf_count;
        refresh_pulse <= 1'b1;
        rf_count <= (rf_count == fmsbp_pkg::ROW_LAST) ? fmsbp_pkg::ROW_RST
                    : rf_count + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift-in register fed through the fifo
  logic [7:0] in_word;
  logic fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out;
  assign in_word = s_dir ? pa_s : pb_s;

  fmsbp_fifo #(.WIDTH(fmsbp_pkg::WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_data(in_word),
    .in_valid(sic_rise),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(!ws_fall)
  );

  logic [7:0] sin_reg [fmsbp_pkg::WORDS];
  logic [2:0] sin_ptr;
  logic sin_full;
  logic [63:0] transfer_latch;
  logic take_word;
  assign take_word = fifo_out_valid && !ws_fall;

  // words still in the fifo at the strobe edge join the next transfer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sin_ptr <= fmsbp_pkg::PTR_RST;
      sin_full <= 1'b0;
      for (int i = 0; i < fmsbp_pkg::WORDS; i++) begin
        sin_reg[i] <= fmsbp_pkg::WORD_ZERO;
      end
    end else if (!s_rst_n) begin
      sin_ptr <= fmsbp_pkg::PTR_RST;
      sin_full <= 1'b0;
    end else if (ws_fall && ce_low) begin
      sin_ptr <= fmsbp_pkg::PTR_RST;
      sin_full <= 1'b0;
    end else if (take_word) begin
      // once full it shifts, so an overrun drops the oldest word, not the newest
      if (sin_full) begin
        for (int i = 0; i < fmsbp_pkg::WORDS - 1; i++) begin
          sin_reg[i] <= sin_reg[i+1];
        end
        sin_reg[fmsbp_pkg::WORDS-1] <= fifo_out;
      end else begin
        sin_reg[sin_ptr] <= fifo_out;
        sin_ptr <= sin_ptr + 3'h1;
        sin_full <= (sin_ptr == 3'h7);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_full <= 1'b0;
    end else begin
      fifo_full <= !fifo_in_ready;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer latch and array
  logic [63:0] rd_block;
  logic rd_pend;
  logic arr_wr;
  logic arr_rd;
  assign arr_wr = ce_low && we_low && lat_sel && !wr_done;
  assign arr_rd = rs_fall && ce_low && lat_sel;

  fmsbp_array #(.AW(ARRAY_AW), .DW(fmsbp_pkg::BLOCK_W)) u_array (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .addr(blk_index(lat_addr)),
    .wr_en(arr_wr),
    .wr_data(transfer_latch),
    .rd_en(arr_rd),
    .rd_data(rd_block)
  );

  // one write per low period of the array write strobe; allows rmw in one cycle
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_done <= 1'b0;
    end else if (!ce_low || !we_low) begin
      wr_done <= 1'b0;
    end else if (arr_wr) begin
      wr_done <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      transfer_latch <= fmsbp_pkg::BLOCK_RST;
    end else if (ws_fall && ce_low) begin
      for (int i = 0; i < fmsbp_pkg::WORDS; i++) begin
        transfer_latch[i*8 +: 8] <= sin_reg[i];
      end
    end else if (rd_pend) begin
      transfer_latch <= rd_block;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // shift-out loop
  logic [63:0] sout_reg;
  logic [2:0] sout_ptr;
  logic [7:0] out_word;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_pend <= 1'b0;
      sout_reg <= fmsbp_pkg::BLOCK_RST;
      sout_ptr <= fmsbp_pkg::PTR_RST;
      out_word <= fmsbp_pkg::WORD_ZERO;
    end else begin
      rd_pend <= arr_rd;
      if (rd_pend) begin
        sout_reg <= rd_block;
        sout_ptr <= fmsbp_pkg::PTR_RST;
      end else if (soc_rise) begin
        out_word <= sout_reg[sout_ptr*8 +: 8];
        sout_ptr <= sout_ptr + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin drivers; oe_n high until a defined sample of output enable
  logic [7:0] drive;
  assign drive = s_fz ? fmsbp_pkg::WORD_ZERO : out_word;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
      port_a_oe_n <= 8'hFF;
      port_b_oe_n <= 8'hFF;
    end else begin
      port_a_out <= drive;
      port_b_out <= drive;
      port_a_oe_n <= (s_oe_n || s_dir) ? 8'hFF : 8'h00;
      port_b_oe_n <= (s_oe_n || !s_dir) ? 8'hFF : 8'h00;
    end
  end
endmodule

// file: dv/fmsbp_vcm.sv
/*
  fmsbp_vcm: controller-side serial model; makes both serial clocks and input data.
  assumes: called from the bench after a core_clk edge; 160 ns serial period.
*/
`timescale 1ns/10ps
module fmsbp_vcm (
  input wire logic core_clk,
  output logic serial_in_clk,
  output logic serial_out_clk,
  output logic [7:0] data
);
  initial begin
    serial_in_clk = 1'b0;
    serial_out_clk = 1'b0;
    data = 8'hA5;
  end
  ////////////////////////////////////////////////////////////////////////////
  // clocks stand still between calls; 10 core cycles per phase
  task automatic sin(input logic [7:0] w);
    data <= w;
    repeat (9) @(posedge core_clk);
    serial_in_clk <= 1'b1;
    repeat (10) @(posedge core_clk);
    serial_in_clk <= 1'b0;
    // released data shows the inverse so a stale copy cannot pass
    data <= ~w;
    @(posedge core_clk);
  endtask
  task automatic sout;
    serial_out_clk <= 1'b1;
    repeat (10) @(posedge core_clk);
    serial_out_clk <= 1'b0;
    repeat (10) @(posedge core_clk);
  endtask
endmodule

// file: dv/fmsbp_chk_sva.sv
/*
  fmsbp_chk: concurrent checks on the fmsbp_top ports.
  assumes: bound to fmsbp_top; one clock domain, async reset.
*/
`timescale 1ns/10ps
module fmsbp_chk (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [17:0] addr,
  input wire logic cycle_strobe_n,
  input wire logic block_sel,
  input wire logic out_enable_n,
  input wire logic serial_out_clk,
  input wire logic port_direction_sel,
  input wire logic force_zero_out,
  input wire logic auto_refresh_n,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe_n,
  input wire logic [8:0] refresh_row,
  input wire logic refresh_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  AST_RESET_HIZ: assert property ($rose(arst_n) |->
    port_a_oe_n == 8'hFF && port_b_oe_n == 8'hFF) else $error("pins driven at reset");
  AST_OE_HIZ: assert property (out_enable_n [*6] |->
    port_a_oe_n == 8'hFF && port_b_oe_n == 8'hFF) else $error("pins driven, oe high");
  AST_DIR_HI: assert property ((!out_enable_n && port_direction_sel) [*6] |->
    port_a_oe_n == 8'hFF && port_b_oe_n == 8'h00) else $error("wrong port, dir high");
  AST_DIR_LO: assert property ((!out_enable_n && !port_direction_sel) [*6] |->
    port_a_oe_n == 8'h00 && port_b_oe_n == 8'hFF) else $error("wrong port, dir low");
  AST_FORCE: assert property ((!out_enable_n && force_zero_out) [*6] |->
    (port_a_out & ~port_a_oe_n) == 8'h00 && (port_b_out & ~port_b_oe_n) == 8'h00)
    else $error("forced data not low");
  // settle time after a clock rise is well inside one high phase
  AST_HOLD: assert property ((!serial_out_clk && !force_zero_out) [*8] |->
    $stable(port_a_out) && $stable(port_b_out)) else $error("word changed between clocks");
  AST_PULSE: assert property (refresh_pulse |=> !refresh_pulse)
    else $error("refresh pulse too long");
  AST_AUTO: assert property ($fell(auto_refresh_n) && cycle_strobe_n |->
    ##[2:8] refresh_pulse) else $error("auto refresh missing");
  AST_CE_REF: assert property ($fell(cycle_strobe_n) && !block_sel |->
    ##[2:8] refresh_pulse ##[0:1] refresh_row == addr[8:0]) else $error("row refresh wrong");
endmodule

// file: dv/fmsbp_tb_top.sv
/*
  fmsbp_tb_top: self-checking bench for fmsbp_top.
  assumes: fmsbp_vcm makes serial traffic; fmsbp_chk bound at the foot.
*/
`timescale 1ns/10ps
module fmsbp_tb_top;
  logic core_clk, arst_n, cycle_strobe_n, block_sel, out_enable_n, write_strobe_n;
  logic array_write_n, read_strobe_n, port_direction_sel, force_zero_out;
  logic auto_refresh_n, internal_reset_n, serial_in_clk, serial_out_clk;
  logic fifo_full, refresh_pulse;
  logic [17:0] addr;
  logic [8:0] refresh_row;
  logic [7:0] vcm_data, port_a_in, port_a_out, port_a_oe_n;
  logic [7:0] port_b_in, port_b_out, port_b_oe_n;
  int mismatches, n_tests;
  localparam logic [17:0] ADR_X = 18'h00E05;
  localparam logic [17:0] ADR_Y = 18'h23F0D;
  ////////////////////////////////////////////////////////////////////////////
  assign port_a_in = (port_a_out & ~port_a_oe_n) | (vcm_data & port_a_oe_n);
  assign port_b_in = (port_b_out & ~port_b_oe_n) | (vcm_data & port_b_oe_n);
  fmsbp_top u_fmsbp_top (.core_clk, .arst_n, .addr, .cycle_strobe_n, .block_sel,
    .out_enable_n, .write_strobe_n, .array_write_n, .read_strobe_n, .serial_in_clk,
    .serial_out_clk, .port_direction_sel, .force_zero_out, .auto_refresh_n,
    .internal_reset_n, .port_a_in, .port_a_out, .port_a_oe_n, .port_b_in, .port_b_out,
    .port_b_oe_n, .refresh_row, .refresh_pulse, .fifo_full);
  fmsbp_vcm u_fmsbp_vcm (.core_clk, .serial_in_clk, .serial_out_clk, .data(vcm_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk_word(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t word %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_row(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t row %h exp %h", $time, got, exp);
    end
  endtask
  task automatic fill(input logic [3:0] s, input int n);
    for (int k = 0; k < n; k++) begin
      u_fmsbp_vcm.sin({s, 4'(k)});
    end
  endtask
  // strobes fall read, latch, write, so one cycle can read then write back
  task automatic acc(input logic [17:0] a, input logic sel, input logic [2:0] op);
    addr <= a;
    block_sel <= sel;
    cyc(1);
    cycle_strobe_n <= 1'b0;
    cyc(6);
    read_strobe_n <= !op[2];
    cyc(6);
    write_strobe_n <= !op[1];
    cyc(6);
    array_write_n <= !op[0];
    cyc(6);
    cycle_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    array_write_n <= 1'b1;
    cyc(8);
  endtask
  task automatic rdchk(input logic [3:0] s, input logic [3:0] first);
    logic [7:0] e;
    for (int k = 0; k < 10; k++) begin
      u_fmsbp_vcm.sout();
      e = {s, 4'(first + k % 8)};
      chk_word(port_direction_sel ? port_b_out : port_a_out, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    chk_word(port_a_oe_n, 8'hFF);
    chk_word(port_b_oe_n, 8'hFF);
    u_fmsbp_vcm.sout();
    internal_reset_n <= 1'b0;
    cyc(6);
    internal_reset_n <= 1'b1;
    cyc(6);
    for (int k = 1; k <= 271; k++) begin
      auto_refresh_n <= 1'b0;
      cyc(6);
      auto_refresh_n <= 1'b1;
      cyc(6);
      chk_row(refresh_row, 9'((k - 1) % 270));
    end
    $display("t_init done");
  endtask
  task automatic t_wr_rd;
    port_direction_sel <= 1'b1;
    out_enable_n <= 1'b0;
    cyc(8);
    chk_word(port_a_oe_n, 8'hFF);
    chk_word(port_b_oe_n, 8'h00);
    fill(4'h1, 8);
    chk_word({7'h00, fifo_full}, 8'h00);
    acc(ADR_X, 1'b1, 3'b011);
    acc(ADR_X, 1'b1, 3'b100);
    rdchk(4'h1, 4'h0);
    $display("t_wr_rd done");
  endtask
  task automatic t_rmw;
    fill(4'h2, 9);
    acc(ADR_X, 1'b1, 3'b111);
    rdchk(4'h1, 4'h0);
    port_direction_sel <= 1'b0;
    cyc(8);
    chk_word(port_a_oe_n, 8'h00);
    chk_word(port_b_oe_n, 8'hFF);
    acc(ADR_X, 1'b1, 3'b100);
    rdchk(4'h2, 4'h1);
    $display("t_rmw done");
  endtask
  task automatic t_refuse;
    fill(4'h3, 8);
    acc(ADR_X, 1'b0, 3'b011);
    chk_row(refresh_row, ADR_X[8:0]);
    acc(ADR_Y, 1'b1, 3'b011);
    acc(ADR_X, 1'b1, 3'b100);
    rdchk(4'h2, 4'h1);
    acc(ADR_Y, 1'b1, 3'b100);
    rdchk(4'h3, 4'h0);
    $display("t_refuse done");
  endtask
  task automatic t_force;
    force_zero_out <= 1'b1;
    u_fmsbp_vcm.sout();
    chk_word(port_a_out, 8'h00);
    chk_word(port_a_oe_n, 8'h00);
    out_enable_n <= 1'b1;
    cyc(8);
    chk_word(port_a_oe_n, 8'hFF);
    force_zero_out <= 1'b0;
    cyc(8);
    chk_word(port_b_oe_n, 8'hFF);
    $display("t_force done");
  endtask
  task automatic print_verdict;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    {arst_n, block_sel, port_direction_sel, force_zero_out} = 4'h0;
    {cycle_strobe_n, out_enable_n, write_strobe_n, array_write_n} = 4'hF;
    {read_strobe_n, auto_refresh_n, internal_reset_n} = 3'h7;
    addr = 18'h00000;
    mismatches = 0;
    n_tests = 0;
    cyc(5);
    arst_n <= 1'b1;
    cyc(6);
    t_init;
    t_wr_rd;
    t_rmw;
    t_refuse;
    t_force;
    print_verdict;
  end
  // whole run is near 5k cycles; eight times that means a hang
  initial begin
    cyc(40000);
    mismatches++;
    print_verdict;
  end
endmodule
bind fmsbp_top fmsbp_chk u_fmsbp_chk (.core_clk, .arst_n, .addr, .cycle_strobe_n,
  .block_sel, .out_enable_n, .serial_out_clk, .port_direction_sel, .force_zero_out,
  .auto_refresh_n, .port_a_out, .port_a_oe_n, .port_b_out, .port_b_oe_n, .refresh_row,
  .refresh_pulse);
